// ---- tm_cfg.svh ----
`ifndef TM_CFG_SVH
`define TM_CFG_SVH
// command indices
`define IX_R1 8'h01
`define IX_EXT 8'h09
`define IX_MFG 8'h0a
`define IX_DEV 8'h0e
`define IX_OV1 8'h21
`define IX_OV4 8'h24
`define IX_OV5 8'h25
`define IX_OV6 8'h26
`define IX_CFG1 8'h41
`define IX_CFG2 8'h42
`define IX_CFG3 8'h43
`define IX_ST1 8'h44
`define IX_ST2 8'h45
`define IX_ST3 8'h46
// control 1 fields, control 1 and 3 write masks
`define C1_STOP 7
`define C1_POR 6
`define C1_TMO 5
`define C1_FAST 4
`define C1_RCAN 3
`define C1_MASK 8'hb8
`define C3_MASK 8'h39
// power-on values of the limits
`define AL_POR '{8'h6e, 8'h7f, 8'h64, 8'h64, 8'h64, 8'h64, 8'h5a}
`define OV_POR '{8'h6e, 8'h7f, 8'h5a, 8'h5a}
// result codes, scaling, hysteresis and alert response address
`define FAULT_CODE 8'hff
`define SHORT_CODE 8'hee
`define SAT_MAX 8'h7f
`define TH_SAT 12'h500
`define TH_LSB_MV 12'h005
`define HYST 9'h004
`define ARA_ADDR 7'h0c
// timing
`define CLK_MHZ 100
`define FAULT_MS 4
`define TOUT_MS 25
`define MS_CYC(ms) ((ms) * 1000 * `CLK_MHZ)
`endif

// ---- tm_pkg.sv ----
package tm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b011,
    ST_WR = 3'b010,
    ST_RD = 3'b110,
    ST_RACK = 3'b111
  } bus_st_e;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] chan_t;
endpackage : tm_pkg

// ---- temp_monitor_alarm_logic.sv ----
`timescale 1ns/1ns
`include "tm_cfg.svh"
module temp_monitor_alarm_logic import tm_pkg::*; #(
  parameter int FAULT_CYC = `MS_CYC(`FAULT_MS),
  parameter int TOUT_CYC = `MS_CYC(`TOUT_MS),
  parameter logic [6:0] SLV_ADDR = 7'h2a,
  parameter byte_t MFG_ID = 8'h3c, // arbitrary value
  parameter byte_t DEV_ID = 8'h21 // arbitrary value
) (
  // clock and reset
  input logic core_clk,
  input logic arst_n,
  // serial link, scl is the link clock
  input logic scl_clk,
  input logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // open-drain alarm pins
  output logic alert_out,
  output logic alert_oe,
  output logic overtemp_out,
  output logic overtemp_oe,
  // converter side
  output chan_t adc_chan,
  output logic adc_run,
  output logic adc_fast,
  output logic adc_rcancel,
  input logic adc_done,
  input logic adc_short,
  input logic [11:0] adc_raw
);
  localparam int FW = $clog2(FAULT_CYC + 1);
  localparam int TW = $clog2(TOUT_CYC + 1);
  localparam byte_t AL_POR [1:7] = `AL_POR;
  localparam byte_t OV_POR [0:3] = `OV_POR;

  // reset release, core clock domain only
  logic [1:0] rs_q;
  logic rst_n;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) rs_q <= 2'h0;
    else rs_q <= {rs_q[0], 1'b1};
  end
  assign rst_n = rs_q[1];

  // link side: each sampled bit flips the toggle of its value
  logic t0_q, t1_q, t0_d, t1_d;
  always_comb begin
    t0_d = t0_q ^ ~sda_in;
    t1_d = t1_q ^ sda_in;
  end
  // scl idles high, so it cannot clock a release stage before the first
  // frame; the toggles leave reset directly while the link clock is still
  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      t0_q <= 1'b0;
      t1_q <= 1'b0;
    end else begin
      t0_q <= t0_d;
      t1_q <= t1_d;
    end
  end

  // crossings into the core clock, third stage only for edges
  logic [2:0] s0_q, s1_q, sc_q, sd_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s0_q <= 3'h0;
      s1_q <= 3'h0;
      sc_q <= 3'h7;
      sd_q <= 3'h7;
    end else begin
      s0_q <= {s0_q[1:0], t0_q};
      s1_q <= {s1_q[1:0], t1_q};
      sc_q <= {sc_q[1:0], scl_clk};
      sd_q <= {sd_q[1:0], sda_in};
    end
  end
  logic bit_ev, bit_v, fall_ev, start_ev, stop_ev;
  assign bit_v = s1_q[2] ^ s1_q[1];
  assign bit_ev = bit_v | (s0_q[2] ^ s0_q[1]);
  assign fall_ev = sc_q[2] & ~sc_q[1];
  assign start_ev = sc_q[2] & sc_q[1] & sd_q[2] & ~sd_q[1];
  assign stop_ev = sc_q[2] & sc_q[1] & ~sd_q[2] & sd_q[1];

  // register and alarm state
  byte_t temp_q [1:7], temp_d [1:7];
  byte_t alim_q [1:7], alim_d [1:7];
  byte_t olim_q [0:3], olim_d [0:3];
  logic [2:0] ext_q, ext_d;
  byte_t c1_q, c1_d, c3_q, c3_d, ov_q, ov_d;
  logic [6:0] c2_q, c2_d, alst_q, alst_d, flt_q, flt_d;
  logic alert_q, alert_d, soft_q, soft_d, frz_q, frz_d;
  logic [TW-1:0] frt_q, frt_d;

  // bus engine state
  bus_st_e st_q, st_d;
  byte_t sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d, rd_byte, newb;
  logic [2:0] cnt_q, cnt_d;
  logic rw_q, rw_d, ara_q, ara_d, ack_q, ack_d, lost_q, lost_d;
  logic wb_q, wb_d, oe_q, oe_d, wr_q, wr_d, rd_q, rd_d, arw_q, arw_d;
  logic [TW-1:0] tmo_q, tmo_d;

  // sequencer state
  chan_t chan_q, chan_d, seq_q, seq_d;
  logic [FW-1:0] ftm_q, ftm_d;
  logic run_q, run_d, fault_ev, res_ev, ovo_q, lo_q;

  // read data for the pointed register
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_q[7:3] == 5'h00 && ptr_q[2:0] != 3'h0) rd_byte = temp_q[ptr_q[2:0]];
    if (ptr_q[7:3] == 5'h02 && ptr_q[2:0] != 3'h0) rd_byte = alim_q[ptr_q[2:0]];
    case (ptr_q)
      `IX_OV1: rd_byte = olim_q[0];
      `IX_OV4: rd_byte = olim_q[1];
      `IX_OV5: rd_byte = olim_q[2];
      `IX_OV6: rd_byte = olim_q[3];
      `IX_EXT: rd_byte = {ext_q, 5'h00};
      `IX_MFG: rd_byte = MFG_ID;
      `IX_DEV: rd_byte = DEV_ID;
      `IX_CFG1: rd_byte = c1_q;
      `IX_CFG2: rd_byte = {1'b0, c2_q};
      `IX_CFG3: rd_byte = c3_q;
      `IX_ST1: rd_byte = {1'b0, alst_q};
      `IX_ST2: rd_byte = ov_q;
      `IX_ST3: rd_byte = {1'b0, flt_q};
      default: ;
    endcase
  end

  // bus engine: address, pointer, write, read and alert response
  assign newb = {sh_q[6:0], bit_v};
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    rw_d = rw_q;
    ara_d = ara_q;
    ack_d = ack_q;
    lost_d = lost_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    wb_d = wb_q;
    oe_d = oe_q;
    wr_d = 1'b0;
    rd_d = 1'b0;
    arw_d = 1'b0;
    tmo_d = (st_q != ST_IDLE && !sc_q[2]) ? tmo_q + TW'(1) : '0;
    if (start_ev) begin
      st_d = ST_ADDR;
      cnt_d = 3'h0;
      wb_d = 1'b0;
      lost_d = 1'b0;
      oe_d = 1'b0;
    end else if (stop_ev || (tmo_q == TW'(TOUT_CYC) && !c1_q[`C1_TMO])) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (bit_ev) begin
      unique case (st_q)
        ST_IDLE: ;
        ST_ADDR, ST_WR: begin
          sh_d = newb;
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            st_d = ST_ACK;
            ack_d = 1'b1;
            if (st_q == ST_ADDR) begin
              rw_d = bit_v;
              ara_d = sh_q[6:0] == `ARA_ADDR;
              if (ara_d) ack_d = bit_v & alert_q;
              else ack_d = sh_q[6:0] == SLV_ADDR;
              if (!ack_d) st_d = ST_IDLE;
            end else if (!wb_q) begin
              ptr_d = newb;
              wb_d = 1'b1;
            end else begin
              wr_d = 1'b1;
            end
          end
        end
        ST_ACK: begin
          cnt_d = 3'h0;
          st_d = rw_q ? ST_RD : ST_WR;
          tx_d = ara_q ? {SLV_ADDR, 1'b0} : rd_byte;
          rd_d = rw_q & ~ara_q;
        end
        ST_RD: begin
          if (bit_v != tx_q[7]) lost_d = 1'b1;
          tx_d = {tx_q[6:0], 1'b0};
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            st_d = ST_RACK;
            arw_d = ara_q & ~lost_d;
          end
        end
        ST_RACK: begin
          cnt_d = 3'h0;
          st_d = bit_v ? ST_IDLE : ST_RD;
          tx_d = rd_byte;
          rd_d = ~bit_v & ~ara_q;
        end
        default: st_d = ST_IDLE;
      endcase
    end
    // drive set on each scl fall and held through the high phase, cleared by start or stop; a losing responder goes quiet
    if (fall_ev) oe_d = (st_q == ST_ACK && ack_q) || (st_q == ST_RD && !tx_q[7] && !lost_q);
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 3'h0;
      rw_q <= 1'b0;
      ara_q <= 1'b0;
      ack_q <= 1'b0;
      lost_q <= 1'b0;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      wb_q <= 1'b0;
      oe_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      arw_q <= 1'b0;
      tmo_q <= '0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      rw_q <= rw_d;
      ara_q <= ara_d;
      ack_q <= ack_d;
      lost_q <= lost_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      wb_q <= wb_d;
      oe_q <= oe_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      arw_q <= arw_d;
      tmo_q <= tmo_d;
    end
  end

  // channel sequencer with open-diode timeout and standby abort
  assign fault_ev = run_q & ~adc_done & (ftm_q == FW'(FAULT_CYC - 1));
  assign res_ev = run_q & (adc_done | fault_ev);
  always_comb begin
    run_d = ~c1_q[`C1_STOP];
    ftm_d = run_q ? ftm_q + FW'(1) : '0;
    chan_d = chan_q;
    seq_d = seq_q;
    if (res_ev) begin
      ftm_d = '0;
      if (c1_q[`C1_FAST] && chan_q != 3'h1) begin
        chan_d = 3'h1;
      end else begin
        chan_d = seq_q;
        seq_d = (seq_q == 3'h7) ? 3'h1 : seq_q + 3'h1;
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      ftm_q <= '0;
      chan_q <= 3'h1;
      seq_q <= 3'h2;
    end else begin
      run_q <= run_d;
      ftm_q <= ftm_d;
      chan_q <= chan_d;
      seq_q <= seq_d;
    end
  end

  // result formatting and compare operands
  byte_t hi_w, ol_w;
  logic [2:0] ext_w, sb_w, ob_w;
  logic gt_w, oc_w;
  always_comb begin
    ext_w = 3'h0;
    if (fault_ev) hi_w = `FAULT_CODE;
    else if (adc_short) hi_w = `SHORT_CODE;
    else if (chan_q >= 3'h4 && chan_q <= 3'h6)
      hi_w = (adc_raw >= `TH_SAT) ? 8'hff : 8'(adc_raw / `TH_LSB_MV);
    else if (adc_raw[11]) hi_w = 8'h00;
    else if (adc_raw[10]) hi_w = `SAT_MAX;
    else begin
      hi_w = {1'b0, adc_raw[9:3]};
      ext_w = adc_raw[2:0];
    end
    sb_w = (chan_q == 3'h7) ? 3'h6 : 3'h6 - chan_q;
    oc_w = chan_q == 3'h1 || (chan_q >= 3'h4 && chan_q <= 3'h6);
    ob_w = (chan_q == 3'h1) ? 3'h0 : 3'(4'h9 - {1'b0, chan_q});
    ol_w = olim_q[(chan_q == 3'h1) ? 2'h0 : 2'(chan_q - 3'h3)];
    gt_w = hi_w > alim_q[chan_q];
  end

  // registers, status, alarm latch and freeze
  always_comb begin
    temp_d = temp_q;
    alim_d = alim_q;
    olim_d = olim_q;
    ext_d = ext_q;
    c1_d = c1_q;
    c2_d = c2_q;
    c3_d = c3_q;
    alst_d = alst_q;
    ov_d = ov_q;
    flt_d = flt_q;
    soft_d = 1'b0;
    frz_d = frz_q;
    frt_d = (frz_q && !c1_q[`C1_TMO]) ? frt_q + TW'(1) : '0;
    alert_d = alert_q & ~((rd_q && ptr_q == `IX_ST1) || arw_q);
    if (wr_q) begin
      if (ptr_q[7:3] == 5'h02 && ptr_q[2:0] != 3'h0) alim_d[ptr_q[2:0]] = sh_q;
      case (ptr_q)
        `IX_OV1: olim_d[0] = sh_q;
        `IX_OV4: olim_d[1] = sh_q;
        `IX_OV5: olim_d[2] = sh_q;
        `IX_OV6: olim_d[3] = sh_q;
        `IX_CFG1: begin
          c1_d = sh_q & `C1_MASK;
          soft_d = sh_q[`C1_POR];
        end
        `IX_CFG2: c2_d = sh_q[6:0];
        `IX_CFG3: c3_d = sh_q & `C3_MASK;
        default: ;
      endcase
    end
    if (rd_q && ptr_q == `IX_EXT) begin
      frz_d = 1'b1;
      frt_d = '0;
    end else if ((rd_q && ptr_q == `IX_R1) || frt_q == TW'(TOUT_CYC)) begin
      frz_d = 1'b0;
    end
    if (res_ev) begin
      if (!(chan_q == 3'h1 && frz_q)) temp_d[chan_q] = hi_w;
      if (chan_q == 3'h1) ext_d = ext_w;
      flt_d[sb_w] = fault_ev;
      if (!fault_ev) begin
        alst_d[sb_w] = gt_w;
        if (gt_w && !c2_q[sb_w]) alert_d = 1'b1;
        if (oc_w && hi_w > ol_w) ov_d[ob_w] = 1'b1;
        else if (oc_w && {1'b0, hi_w} + `HYST < {1'b0, ol_w}) ov_d[ob_w] = 1'b0;
      end
    end
    if (soft_q) begin
      temp_d = '{default: 8'h00};
      alim_d = AL_POR;
      olim_d = OV_POR;
      ext_d = 3'h0;
      c1_d = 8'h00;
      c2_d = 7'h00;
      c3_d = 8'h00;
      alst_d = 7'h00;
      ov_d = 8'h00;
      flt_d = 7'h00;
      alert_d = 1'b0;
      frz_d = 1'b0;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_q <= '{default: 8'h00};
      alim_q <= AL_POR;
      olim_q <= OV_POR;
      ext_q <= 3'h0;
      c1_q <= 8'h00;
      c2_q <= 7'h00;
      c3_q <= 8'h00;
      alst_q <= 7'h00;
      ov_q <= 8'h00;
      flt_q <= 7'h00;
      alert_q <= 1'b0;
      soft_q <= 1'b0;
      frz_q <= 1'b0;
      frt_q <= '0;
    end else begin
      temp_q <= temp_d;
      alim_q <= alim_d;
      olim_q <= olim_d;
      ext_q <= ext_d;
      c1_q <= c1_d;
      c2_q <= c2_d;
      c3_q <= c3_d;
      alst_q <= alst_d;
      ov_q <= ov_d;
      flt_q <= flt_d;
      alert_q <= alert_d;
      soft_q <= soft_d;
      frz_q <= frz_d;
      frt_q <= frt_d;
    end
  end

  // pin drivers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovo_q <= 1'b0;
      lo_q <= 1'b0;
    end else begin
      ovo_q <= |(ov_q & ~c3_q);
      lo_q <= 1'b0;
    end
  end
  assign sda_oe = oe_q;
  assign sda_out = lo_q;
  assign alert_oe = alert_q;
  assign alert_out = lo_q;
  assign overtemp_oe = ovo_q;
  assign overtemp_out = lo_q;
  assign adc_chan = chan_q;
  assign adc_run = run_q;
  assign adc_fast = c1_q[`C1_FAST];
  assign adc_rcancel = c1_q[`C1_RCAN];

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_lose;
    st_q == ST_RD && ara_q && bit_ev && bit_v != tx_q[7];
  endsequence
  sequence s_hot;
    res_ev && !fault_ev && oc_w && hi_w > ol_w && c3_q[ob_w] == 1'b0;
  endsequence
  open_code_a: assert property (fault_ev && chan_q != 3'h1 && !soft_q
    |=> temp_q[$past(chan_q)] == `FAULT_CODE && flt_q != 7'h00)
    else $error("open fault code not stored");
  open_quiet_a: assert property (fault_ev && !alert_q && !soft_q |=> !alert_q)
    else $error("open fault raised alert");
  fault_adv_a: assert property (fault_ev && !c1_q[`C1_FAST] |=> chan_q == $past(seq_q))
    else $error("no advance after fault");
  alert_set_a: assert property (res_ev && !fault_ev && gt_w && !c2_q[sb_w] && !soft_q
    |=> alert_q ##1 alert_oe)
    else $error("alert not raised");
  alert_clr_a: assert property (rd_q && ptr_q == `IX_ST1 && !res_ev |=> !alert_q)
    else $error("status read kept alert");
  ara_lose_a: assert property (s_lose |=> lost_q && !arw_q)
    else $error("losing responder kept sending");
  overtemp_out_on_a: assert property (s_hot and !soft_q |-> ##2 overtemp_oe)
    else $error("overtemp not raised");
  overtemp_out_hold_a: assert property (res_ev && !fault_ev && oc_w && ov_q[ob_w] && !soft_q
    && {1'b0, hi_w} + `HYST >= {1'b0, ol_w} |=> ov_q[$past(ob_w)])
    else $error("overtemp released inside hysteresis");
  soft_rst_a: assert property (soft_q |=> c1_q == 8'h00 && c2_q == 7'h00 && !soft_q)
    else $error("soft reset incomplete");
  standby_a: assert property (!run_q && adc_done && !soft_q
    |=> $stable(flt_q) && $stable(alst_q))
    else $error("standby result stored");
endmodule : temp_monitor_alarm_logic

// ---- smbus_host_model.sv ----
`timescale 1ns/1ns
module smbus_host_model import tm_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  // two-wire bus, released lines float high
  output logic scl_clk,
  output logic sda_oe,
  input wire logic sda
);
  logic slow;
  logic in_frame;

  // bus parked released, clock still
  initial begin
    scl_clk = 1'b1;
    sda_oe = 1'b0;
    slow = 1'b0;
    in_frame = 1'b0;
  end

  // one pulse; low phase stretched where the device answers late
  task automatic bit_io(input logic v, output logic r);
    scl_clk = 1'b0;
    #2 sda_oe = ~v;
    #(slow ? 58 : 13) scl_clk = 1'b1;
    r = sda;
    #15;
  endtask : bit_io

  // start, or repeated start inside a frame
  task automatic start();
    #3;
    if (in_frame) begin
      scl_clk = 1'b0;
      #2 sda_oe = 1'b0;
      #58 scl_clk = 1'b1;
    end
    #40 sda_oe = 1'b1;
    #40 in_frame = 1'b1;
  endtask : start

  // stop, clock left high afterwards
  task automatic stop();
    scl_clk = 1'b0;
    #2 sda_oe = 1'b1;
    #58 scl_clk = 1'b1;
    #40 sda_oe = 1'b0;
    #40 in_frame = 1'b0;
  endtask : stop

  // byte out, msb first, then the device's acknowledge
  task automatic send_byte(input byte_t b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      slow = (i == 7);
      bit_io(b[i], r);
    end
    slow = 1'b1;
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send_byte

  // byte in, then our acknowledge or not
  task automatic get_byte(input logic last, output byte_t b);
    logic r;
    slow = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask : get_byte

  // receive byte from any address
  task automatic recv(input logic [6:0] a, output byte_t d, output logic ack);
    start();
    send_byte({a, 1'b1}, ack);
    get_byte(1'b1, d);
    stop();
  endtask : recv

  // write byte: pointer then data
  task automatic write_reg(input byte_t i, input byte_t d, output logic ack);
    logic a0, a1, a2;
    start();
    send_byte({DEV_ADDR, 1'b0}, a0);
    send_byte(i, a1);
    send_byte(d, a2);
    stop();
    ack = a0 & a1 & a2;
  endtask : write_reg

  // read byte: pointer, repeated start, data
  task automatic read_reg(input byte_t i, output byte_t d, output logic ack);
    logic a0, a1, a2;
    start();
    send_byte({DEV_ADDR, 1'b0}, a0);
    send_byte(i, a1);
    recv(DEV_ADDR, d, a2);
    ack = a0 & a1 & a2;
  endtask : read_reg
endmodule : smbus_host_model

// ---- temp_monitor_alarm_logic_tb.sv ----
`timescale 1ns/1ns
`include "tm_cfg.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module temp_monitor_alarm_logic_tb import tm_pkg::*;;
  localparam int FAULT = 5000;
  localparam logic [6:0] ADDR = 7'h2a;
  logic core_clk, arst_n, scl_clk, host_oe, sda_oe, alert_oe, overtemp_oe;
  logic adc_run, adc_fast, adc_rcancel, adc_done, adc_short;
  chan_t adc_chan;
  logic [11:0] adc_raw;
  logic [11:0] raws [8];
  logic shs [8];
  logic opn [8];
  int n_fail, checked;
  wire sda = ~(sda_oe | host_oe);

  temp_monitor_alarm_logic #(.FAULT_CYC(FAULT), .TOUT_CYC(200), .SLV_ADDR(ADDR))
    temp_monitor_alarm_logic_inst (
    .core_clk(core_clk), .arst_n(arst_n), .scl_clk(scl_clk), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .alert_out(), .alert_oe(alert_oe), .overtemp_out(),
    .overtemp_oe(overtemp_oe), .adc_chan(adc_chan), .adc_run(adc_run),
    .adc_fast(adc_fast), .adc_rcancel(adc_rcancel), .adc_done(adc_done),
    .adc_short(adc_short), .adc_raw(adc_raw));
  smbus_host_model #(.DEV_ADDR(ADDR)) smbus_host_model_inst (
    .scl_clk(scl_clk), .sda_oe(host_oe), .sda(sda));

  // core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic done(input string s);
    $display("test %s ended, %0d checks, %0d errors", s, checked, n_fail);
  endtask : done

  task automatic wr(input byte_t i, input byte_t d);
    logic a;
    smbus_host_model_inst.write_reg(i, d, a);
    @(negedge core_clk);
    `CHK(a, 1'b1)
  endtask : wr

  task automatic expect_reg(input byte_t i, input byte_t e, input byte_t m = 8'hff);
    logic a;
    byte_t d;
    smbus_host_model_inst.read_reg(i, d, a);
    @(negedge core_clk);
    `CHK(d & m, e)
  endtask : expect_reg

  // quiet readings on every channel
  task automatic calm();
    raws = '{12'h000, 12'h0c8, 12'h0c8, 12'h0c8, 12'h064, 12'h064, 12'h064, 12'h0c8};
    shs = '{default: 1'b0};
    opn = '{default: 1'b0};
  endtask : calm

  // eight conversions, one pass over the seven channels and one more; open ones never report
  task automatic sweep();
    int n;
    chan_t c;
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk);
      if (opn[adc_chan]) begin
        c = adc_chan;
        n = 0;
        while (adc_chan === c && n < 6000) begin
          @(posedge core_clk);
          n++;
        end
        if (n == 6000) begin
          n_fail++;
          conclude();
        end
        // the first channel may have been timing before the sweep began
        if (k > 0) `CHK(n + 4 >= FAULT, 1'b1)
      end else begin
        adc_done <= 1'b1;
        adc_raw <= raws[adc_chan];
        adc_short <= shs[adc_chan];
        @(posedge core_clk);
        adc_done <= 1'b0;
        repeat (2) @(posedge core_clk);
      end
    end
  endtask : sweep

  task automatic t_regs();
    logic a;
    byte_t d;
    smbus_host_model_inst.recv(ADDR, d, a);
    `CHK(d, 8'h00)
    expect_reg(`IX_CFG1, 8'h00);
    expect_reg(`IX_CFG2, 8'h00);
    expect_reg(8'h17, 8'h5a);
    expect_reg(`IX_OV6, 8'h5a);
    wr(`IX_CFG1, 8'hbb);
    expect_reg(`IX_CFG1, 8'hb8);
    `CHK({adc_run, adc_fast, adc_rcancel}, 3'b011)
    wr(8'h11, 8'h30);
    wr(`IX_CFG1, 8'h40);
    expect_reg(`IX_CFG1, 8'h00);
    expect_reg(8'h11, 8'h6e);
    `CHK(adc_run, 1'b1)
    done("regs");
  endtask : t_regs

  task automatic t_codes();
    byte_t ex [8] = '{8'h00, 8'h19, 8'h7f, 8'h00, 8'h64, 8'h01, 8'hc8, 8'h19};
    wr(`IX_CFG2, 8'h7f);
    wr(`IX_CFG3, 8'h39);
    raws = '{12'h000, 12'h0c9, 12'h640, 12'hfd8, 12'h1f4, 12'h005, 12'h3e8, 12'h0c8};
    sweep();
    expect_reg(`IX_EXT, 8'h20, 8'he0);
    for (int i = 1; i < 8; i++) begin
      expect_reg(byte_t'(i), ex[i]);
    end
    expect_reg(`IX_ST1, 8'h01, 8'hef);
    `CHK({alert_oe, overtemp_oe}, 2'b00)
    shs[2] = 1'b1;
    sweep();
    expect_reg(8'h02, 8'hee);
    done("codes");
  endtask : t_codes

  task automatic t_alert();
    logic a;
    byte_t d;
    calm();
    wr(`IX_CFG2, 8'h00);
    wr(`IX_CFG3, 8'h00);
    wr(8'h11, 8'h1e);
    raws[1] = 12'h0f8;
    sweep();
    `CHK({alert_oe, adc_run}, 2'b11)
    expect_reg(`IX_ST1, 8'h20);
    `CHK(alert_oe, 1'b0)
    sweep();
    `CHK(alert_oe, 1'b1)
    smbus_host_model_inst.recv(`ARA_ADDR, d, a);
    @(negedge core_clk);
    `CHK({a, d}, {1'b1, ADDR, 1'b0})
    `CHK(alert_oe, 1'b0)
    smbus_host_model_inst.recv(`ARA_ADDR, d, a);
    `CHK(a, 1'b0)
    wr(`IX_CFG2, 8'h20);
    sweep();
    `CHK(alert_oe, 1'b0)
    expect_reg(`IX_ST1, 8'h20);
    done("alert");
  endtask : t_alert

  task automatic t_overtemp();
    logic [11:0] r [4] = '{12'h140, 12'h148, 12'h120, 12'h118};
    logic ex [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    wr(`IX_CFG2, 8'h7f);
    wr(`IX_OV1, 8'h28);
    for (int i = 0; i < 4; i++) begin
      raws[1] = r[i];
      sweep();
      `CHK(overtemp_oe, ex[i])
    end
    wr(`IX_CFG2, 8'h00);
    opn[1] = 1'b1;
    sweep();
    `CHK({alert_oe, overtemp_oe}, 2'b00)
    expect_reg(`IX_ST3, 8'h20);
    expect_reg(`IX_R1, 8'hff);
    done("overtemp");
  endtask : t_overtemp

  // main sequence
  initial begin
    arst_n = 1'b0;
    adc_done = 1'b0;
    adc_short = 1'b0;
    adc_raw = 12'h000;
    n_fail = 0;
    checked = 0;
    calm();
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    t_regs();
    t_codes();
    t_alert();
    t_overtemp();
    conclude();
  end

  // hang guard
  initial begin
    #900000;
    n_fail++;
    conclude();
  end
endmodule : temp_monitor_alarm_logic_tb
